//--- include/irpc_consts.svh
/*
  constants of the interrupt, reset and power control block: offsets, bit
  positions, reset values and counts. assumes it is included by bare name.
*/
// Overview of operation
// - interrupt output is OR of every status bit ANDed with its enable bit, ANDed with function enable outside local bus mode.
// - local bus mode has no global interrupt enable, only per-source enables.
// - merged interrupt state is readable in the config status register.
// - option soft reset holds the controller in reset, except itself.
// - setting option soft reset drives the request/ready line low.
// - clearing option soft reset drives the request/ready line high.
// - core soft reset spares address, configuration and base registers.
// - power-down pin counts only with endec select nonzero; powers all down.
// - control bits: none awake, wake only tx down, power-down bit all down.
// - clearing both wake enable and power-down bit returns to fully awake.
// - power-down bit takes precedence over wake enable.
// - function enable bit is ignored for power state in local bus mode.
`ifndef IRPC_CONSTS_SVH
`define IRPC_CONSTS_SVH

`define IRPC_ADDR_W        4
`define IRPC_DATA_W        16
`define IRPC_NUM_EVT       8
`define IRPC_OFF_EVT_STAT  4'h0
`define IRPC_OFF_EVT_EN    4'h1
`define IRPC_OFF_CFG_OPT   4'h2
`define IRPC_OFF_CFG_STAT  4'h3
`define IRPC_OFF_RX_CTL    4'h4
`define IRPC_OFF_PWR_CTL   4'h5
`define IRPC_OFF_PWR_STAT  4'h6
`define IRPC_OFF_IND_ADDR  4'h7
`define IRPC_OFF_CFG_REGS  4'h8
`define IRPC_OFF_BASE_ADDR 4'h9
`define IRPC_BIT_OPT_SRST  7
`define IRPC_BIT_OPT_FEN   0
`define IRPC_BIT_STAT_INTR 1
`define IRPC_BIT_STAT_PD   0
`define IRPC_BIT_RX_SRST   15
`define IRPC_BIT_PCTL_PD   1
`define IRPC_BIT_PCTL_WAKE 0
`define IRPC_SEL_LO        1
`define IRPC_RST_WORD      16'h0000
`define IRPC_RST_EVT       8'h00
`define IRPC_BOOT_DONE     2'h3
`define IRPC_BOOT_SAMPLE   2'h2

`endif

//--- include/irpc_pkg.sv
/*
  types of the interrupt, reset and power control block.
  assumes irpc_consts.svh is on the include path.
*/
`default_nettype none
`include "irpc_consts.svh"
package irpc_pkg;

  typedef enum logic [3:0] {
    IRPC_AWAKE    = 4'h1,
    IRPC_TX_DOWN  = 4'h2,
    IRPC_ALL_DOWN = 4'h4,
    IRPC_PIN_DOWN = 4'h8
  } irpc_pwr_type;

  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [`IRPC_ADDR_W-1:0] addr;
    logic [`IRPC_DATA_W-1:0] wdata;
  } irpc_bus_type;

  typedef struct packed {
    logic                      tx;
    logic                      rx;
    logic                      link;
    logic                      modem_n;
  } irpc_pwr_out_type;

  typedef struct packed {
    logic [`IRPC_NUM_EVT-1:0] evt_stat;
    logic [`IRPC_NUM_EVT-1:0] evt_en;
    logic                     opt_srst;
    logic                     opt_fen;
    logic                     stat_pd;
    logic [`IRPC_DATA_W-1:0]  rx_ctl;
    logic                     pctl_pd;
    logic                     pctl_wake;
    logic [`IRPC_DATA_W-1:0]  ind_addr;
    logic [`IRPC_DATA_W-1:0]  cfg_regs;
    logic [`IRPC_DATA_W-1:0]  base_addr;
    logic                     lbm;
    logic [1:0]               boot_cnt;
    irpc_pwr_type             pstate;
    irpc_pwr_out_type         pwr;
    logic                     core_rst;
    logic                     req_ready;
    logic                     eep_start;
    logic                     irq;
    logic [3:0]               intr_lines;
    logic [`IRPC_DATA_W-1:0]  rdata;
  } irpc_state_type;

endpackage
`default_nettype wire

//--- src/irpc_sync.sv
/*
  two flip-flop synchroniser for pin levels.
  assumes slowly changing levels; no pulse shorter than two clocks.
*/
`default_nettype none
module irpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_clock_enable,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } irpc_sync_state_type;

  irpc_sync_state_type st_r;
  irpc_sync_state_type st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = i_async;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
    end
    else if (i_clock_enable)
    begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.sync;

endmodule // irpc_sync
`default_nettype wire

//--- src/irpc_top.sv
/*
  interrupt merging, reset distribution and power state control.
  assumes a register master on the same clock, events as one-cycle pulses
  from the core, and pins that are asynchronous levels.
*/
`default_nettype none
`include "irpc_consts.svh"
module irpc_top (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_clock_enable,
  input  wire irpc_pkg::irpc_bus_type   i_bus,
  output var  logic [`IRPC_DATA_W-1:0]  o_rdata,
  input  wire logic [`IRPC_NUM_EVT-1:0] i_irq_event,
  input  wire logic                     i_power_down_pin,
  input  wire logic [1:0]               i_external_endec_select,
  input  wire logic                     i_local_bus_mode_pin,
  output var  logic                     o_irq,
  output var  logic [3:0]               o_interrupt_output_lines,
  output var  logic                     o_request_ready_line,
  output var  logic                     o_core_reset,
  output var  logic                     o_eeprom_read_start,
  output var  irpc_pkg::irpc_pwr_out_type o_power
);
  import irpc_pkg::*;

  localparam irpc_state_type ST_RST = '{
    evt_stat:   `IRPC_RST_EVT,
    evt_en:     `IRPC_RST_EVT,
    opt_srst:   1'b0,
    opt_fen:    1'b0,
    stat_pd:    1'b0,
    rx_ctl:     `IRPC_RST_WORD,
    pctl_pd:    1'b0,
    pctl_wake:  1'b0,
    ind_addr:   `IRPC_RST_WORD,
    cfg_regs:   `IRPC_RST_WORD,
    base_addr:  `IRPC_RST_WORD,
    lbm:        1'b0,
    boot_cnt:   2'h0,
    pstate:     IRPC_AWAKE,
    pwr:        '{tx: 1'b0, rx: 1'b0, link: 1'b0, modem_n: 1'b1},
    core_rst:   1'b0,
    req_ready:  1'b1,
    eep_start:  1'b0,
    irq:        1'b0,
    intr_lines: 4'h0,
    rdata:      `IRPC_RST_WORD
  };

  irpc_state_type st_r;
  irpc_state_type st_nxt;
  logic [3:0]     pins_sync;
  logic           pin_on;
  logic           fen_ok;
  logic           held_opt;
  logic           held_core;
  logic           wr_stat;
  logic           wr_en;
  logic           wr_opt;
  logic           wr_cstat;
  logic           wr_rx;
  logic           wr_pctl;
  logic           wr_ind;
  logic           wr_cfg;
  logic           wr_base;

  irpc_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clock        (i_clock),
    .i_rst_n        (i_rst_n),
    .i_clock_enable (i_clock_enable),
    .i_async        ({i_local_bus_mode_pin, i_external_endec_select,
                      i_power_down_pin}),
    .o_sync         (pins_sync)
  );

  // pin counts only with an external endec selected
  assign pin_on    = pins_sync[0] && (pins_sync[2:1] != 2'h0);
  // soft resets act in the cycle of the write that sets them
  assign held_opt  = wr_opt ? i_bus.wdata[`IRPC_BIT_OPT_SRST] : st_r.opt_srst;
  assign held_core = held_opt || (wr_rx ? i_bus.wdata[`IRPC_BIT_RX_SRST]
                                        : st_r.rx_ctl[`IRPC_BIT_RX_SRST]);
  assign wr_stat   = i_bus.wr && (i_bus.addr == `IRPC_OFF_EVT_STAT);
  assign wr_en     = i_bus.wr && (i_bus.addr == `IRPC_OFF_EVT_EN);
  assign wr_opt    = i_bus.wr && (i_bus.addr == `IRPC_OFF_CFG_OPT);
  assign wr_cstat  = i_bus.wr && (i_bus.addr == `IRPC_OFF_CFG_STAT);
  assign wr_rx     = i_bus.wr && (i_bus.addr == `IRPC_OFF_RX_CTL);
  assign wr_pctl   = i_bus.wr && (i_bus.addr == `IRPC_OFF_PWR_CTL);
  assign wr_ind    = i_bus.wr && (i_bus.addr == `IRPC_OFF_IND_ADDR);
  assign wr_cfg    = i_bus.wr && (i_bus.addr == `IRPC_OFF_CFG_REGS);
  assign wr_base   = i_bus.wr && (i_bus.addr == `IRPC_OFF_BASE_ADDR);

  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.eep_start = 1'b0;
    st_nxt.rdata     = `IRPC_RST_WORD;

    // bus mode and first eeprom read once the pin synchroniser has settled
    if (st_r.boot_cnt != `IRPC_BOOT_DONE)
    begin
      st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
      if (st_r.boot_cnt == `IRPC_BOOT_SAMPLE)
      begin
        st_nxt.lbm       = pins_sync[3];
        st_nxt.eep_start = 1'b1;
      end
    end

    if (wr_opt)
    begin
      st_nxt.opt_srst = i_bus.wdata[`IRPC_BIT_OPT_SRST];
      st_nxt.opt_fen  = i_bus.wdata[`IRPC_BIT_OPT_FEN];
    end
    // setting the option soft reset also reloads from the eeprom
    if (st_nxt.opt_srst && !st_r.opt_srst)
    begin
      st_nxt.eep_start = 1'b1;
    end

    if (wr_stat)
    begin
      st_nxt.evt_stat = st_r.evt_stat & ~i_bus.wdata[`IRPC_NUM_EVT-1:0];
    end
    if (wr_en)
    begin
      st_nxt.evt_en = i_bus.wdata[`IRPC_NUM_EVT-1:0];
    end
    // the status power-down bit is only heeded outside local bus mode
    if (wr_cstat)
    begin
      st_nxt.stat_pd = i_bus.wdata[`IRPC_BIT_STAT_PD];
    end
    if (wr_rx)
    begin
      st_nxt.rx_ctl = i_bus.wdata;
    end
    if (wr_pctl)
    begin
      st_nxt.pctl_pd   = i_bus.wdata[`IRPC_BIT_PCTL_PD];
      st_nxt.pctl_wake = i_bus.wdata[`IRPC_BIT_PCTL_WAKE];
    end
    if (wr_ind)
    begin
      st_nxt.ind_addr = i_bus.wdata;
    end
    if (wr_cfg)
    begin
      st_nxt.cfg_regs = i_bus.wdata;
    end
    if (wr_base)
    begin
      st_nxt.base_addr = i_bus.wdata;
    end

    // new events win over a clear in the same cycle
    st_nxt.evt_stat = st_nxt.evt_stat | i_irq_event;

    // core soft reset keeps address, configuration and base registers
    if (held_core)
    begin
      st_nxt.evt_stat  = `IRPC_RST_EVT;
      st_nxt.evt_en    = `IRPC_RST_EVT;
      st_nxt.stat_pd   = 1'b0;
      st_nxt.pctl_pd   = 1'b0;
      st_nxt.pctl_wake = 1'b0;
    end
    // option soft reset clears everything but its own bit
    if (held_opt)
    begin
      st_nxt.rx_ctl    = `IRPC_RST_WORD;
      st_nxt.opt_fen   = 1'b0;
      st_nxt.ind_addr  = `IRPC_RST_WORD;
      st_nxt.cfg_regs  = `IRPC_RST_WORD;
      st_nxt.base_addr = `IRPC_RST_WORD;
    end

    // function enable matters only outside local bus mode
    fen_ok = st_nxt.lbm || st_nxt.opt_fen;

    // power state from pin and control bits; pin release restores bits
    if (pin_on)
    begin
      st_nxt.pstate = IRPC_PIN_DOWN;
    end
    else if (st_nxt.pctl_pd || !fen_ok || (st_nxt.stat_pd && !st_nxt.lbm))
    begin
      st_nxt.pstate = IRPC_ALL_DOWN;
    end
    else if (st_nxt.pctl_wake)
    begin
      st_nxt.pstate = IRPC_TX_DOWN;
    end
    else
    begin
      st_nxt.pstate = IRPC_AWAKE;
    end

    case (st_nxt.pstate)
      IRPC_AWAKE:
      begin
        st_nxt.pwr = '{tx: 1'b0, rx: 1'b0, link: 1'b0, modem_n: 1'b1};
      end
      IRPC_TX_DOWN:
      begin
        st_nxt.pwr = '{tx: 1'b1, rx: 1'b0, link: 1'b0, modem_n: 1'b1};
      end
      IRPC_ALL_DOWN:
      begin
        st_nxt.pwr = '{tx: 1'b1, rx: 1'b1, link: 1'b1, modem_n: 1'b1};
      end
      default:
      begin
        st_nxt.pwr = '{tx: 1'b1, rx: 1'b1, link: 1'b1, modem_n: 1'b0};
      end
    endcase

    // merged interrupt; only per-source enables gate it in local bus mode
    st_nxt.irq = (|(st_nxt.evt_stat & st_nxt.evt_en)) && fen_ok;
    if (st_nxt.irq)
    begin
      st_nxt.intr_lines = 4'h1 << st_nxt.cfg_regs[`IRPC_SEL_LO +: 2];
    end
    else
    begin
      st_nxt.intr_lines = 4'h0;
    end

    st_nxt.core_rst  = st_nxt.opt_srst || st_nxt.rx_ctl[`IRPC_BIT_RX_SRST];
    st_nxt.req_ready = !st_nxt.opt_srst;

    if (i_bus.rd)
    begin
      if (i_bus.addr == `IRPC_OFF_EVT_STAT)
      begin
        st_nxt.rdata = {8'h00, st_r.evt_stat};
      end
      else if (i_bus.addr == `IRPC_OFF_EVT_EN)
      begin
        st_nxt.rdata = {8'h00, st_r.evt_en};
      end
      else if (i_bus.addr == `IRPC_OFF_CFG_OPT)
      begin
        st_nxt.rdata = {8'h00, st_r.opt_srst, 6'h00, st_r.opt_fen};
      end
      else if (i_bus.addr == `IRPC_OFF_CFG_STAT)
      begin
        st_nxt.rdata = {14'h0000, st_r.irq, st_r.stat_pd};
      end
      else if (i_bus.addr == `IRPC_OFF_RX_CTL)
      begin
        st_nxt.rdata = st_r.rx_ctl;
      end
      else if (i_bus.addr == `IRPC_OFF_PWR_CTL)
      begin
        st_nxt.rdata = {14'h0000, st_r.pctl_pd, st_r.pctl_wake};
      end
      else if (i_bus.addr == `IRPC_OFF_PWR_STAT)
      begin
        st_nxt.rdata = {7'h00, st_r.lbm, 4'h0, st_r.pstate};
      end
      else if (i_bus.addr == `IRPC_OFF_IND_ADDR)
      begin
        st_nxt.rdata = st_r.ind_addr;
      end
      else if (i_bus.addr == `IRPC_OFF_CFG_REGS)
      begin
        st_nxt.rdata = st_r.cfg_regs;
      end
      else if (i_bus.addr == `IRPC_OFF_BASE_ADDR)
      begin
        st_nxt.rdata = st_r.base_addr;
      end
      else
      begin
        st_nxt.rdata = `IRPC_RST_WORD;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= ST_RST;
    end
    else if (i_clock_enable)
    begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata                  = st_r.rdata;
  assign o_irq                    = st_r.irq;
  assign o_interrupt_output_lines = st_r.intr_lines;
  assign o_request_ready_line     = st_r.req_ready;
  assign o_core_reset             = st_r.core_rst;
  assign o_eeprom_read_start      = st_r.eep_start;
  assign o_power                  = st_r.pwr;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  property p_irq_merge;
    o_irq == ((|(st_r.evt_stat & st_r.evt_en)) && (st_r.lbm || st_r.opt_fen));
  endproperty
  a_irq_merge: assert property (p_irq_merge) else $error("irq not merged");

  property p_no_global_en;
    (i_clock_enable && st_r.lbm && (|(st_nxt.evt_stat & st_nxt.evt_en)))
      |=> o_irq && (o_interrupt_output_lines != 4'h0);
  endproperty
  a_no_global_en: assert property (p_no_global_en) else $error("irq gated");

  property p_stat_intr;
    (i_clock_enable && i_bus.rd && (i_bus.addr == `IRPC_OFF_CFG_STAT))
      |=> o_rdata[`IRPC_BIT_STAT_INTR] == $past(o_irq);
  endproperty
  a_stat_intr: assert property (p_stat_intr) else $error("intr bit wrong");

  property p_held;
    st_r.opt_srst |-> o_core_reset && (st_r.ind_addr == `IRPC_RST_WORD);
  endproperty
  a_held: assert property (p_held) else $error("soft reset not held");

  property p_req_low;
    (i_clock_enable && wr_opt && i_bus.wdata[`IRPC_BIT_OPT_SRST] && !st_r.opt_srst)
      |=> !o_request_ready_line && o_eeprom_read_start;
  endproperty
  a_req_low: assert property (p_req_low) else $error("req line not low");

  property p_req_high;
    (i_clock_enable && wr_opt && !i_bus.wdata[`IRPC_BIT_OPT_SRST])
      |=> o_request_ready_line;
  endproperty
  a_req_high: assert property (p_req_high) else $error("req line not high");

  property p_keep_ind;
    (i_clock_enable && st_r.rx_ctl[`IRPC_BIT_RX_SRST] && !held_opt && !wr_ind)
      |=> $stable(st_r.ind_addr);
  endproperty
  a_keep_ind: assert property (p_keep_ind) else $error("address reg lost");

  property p_pin_down;
    (i_clock_enable && pin_on) |=> !o_power.modem_n && o_power.rx && o_power.link;
  endproperty
  a_pin_down: assert property (p_pin_down) else $error("pin not honoured");

  property p_tx_only;
    (i_clock_enable && !pin_on && st_r.lbm && st_nxt.pctl_wake && !st_nxt.pctl_pd)
      |=> o_power.tx && !o_power.rx && !o_power.link;
  endproperty
  a_tx_only: assert property (p_tx_only) else $error("wake state wrong");

  property p_awake;
    (i_clock_enable && !pin_on && st_r.lbm && !st_nxt.pctl_wake && !st_nxt.pctl_pd)
      |=> !o_power.tx && !o_power.rx && o_power.modem_n;
  endproperty
  a_awake: assert property (p_awake) else $error("not awake");

  property p_pd_wins;
    (i_clock_enable && !pin_on && st_nxt.pctl_pd) |=> o_power.rx && o_power.tx;
  endproperty
  a_pd_wins: assert property (p_pd_wins) else $error("precedence lost");

  c_irq:   cover property (o_irq && st_r.lbm);
  c_pin:   cover property (!o_power.modem_n ##1 o_power.modem_n);
  c_srst:  cover property (!o_request_ready_line ##1 o_request_ready_line);
  c_txd:   cover property (st_r.pstate == IRPC_TX_DOWN);

endmodule // irpc_top
`default_nettype wire

//--- test/irpc_host_model.sv
/*
  host processor model driving the register port of the control block.
  assumes the block answers a read in the cycle after the strobe and never
  makes the host wait.
*/
`default_nettype none
`include "irpc_consts.svh"
module irpc_host_model (
  input  wire logic                    i_clock,
  input  wire logic [`IRPC_DATA_W-1:0] i_rdata,
  output var  irpc_pkg::irpc_bus_type  o_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  import irpc_pkg::*;

  initial o_bus = '0;

  // one strobe cycle, then idle; read data taken in the cycle after it
  task automatic access(input  logic                    is_wr,
                        input  logic [`IRPC_ADDR_W-1:0] addr,
                        input  logic [`IRPC_DATA_W-1:0] wdata,
                        output logic [`IRPC_DATA_W-1:0] rdata);
    irpc_bus_type b;
    b.wr = is_wr;
    b.rd = ~is_wr;
    b.addr = addr;
    b.wdata = is_wr ? wdata : '0;
    // a local bus host keeps the status power-down bit clear
    if (is_wr && addr == `IRPC_OFF_CFG_STAT)
    begin
      b.wdata[`IRPC_BIT_STAT_PD] = 1'h0;
    end
    @(posedge i_clock);
    o_bus <= b;
    @(posedge i_clock);
    o_bus <= '0;
    #1;
    rdata = i_rdata;
  endtask
endmodule // irpc_host_model
`default_nettype wire

//--- test/test_irq_reset_power_ctrl.sv
/*
  self-checking bench of the interrupt, reset and power control block.
  assumes the host model file and the package are compiled first.
*/
`default_nettype none
`include "irpc_consts.svh"
`define CHK(got, exp) \
  begin n_compared++; if ((got) !== (exp)) begin \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  err_count++; end end
module test_irq_reset_power_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import irpc_pkg::*;

  logic             clock = 1'h0;
  logic             rst_n = 1'h0;
  irpc_bus_type     bus;
  logic [15:0]      rdata;
  logic [7:0]       irq_event = 8'h00;
  logic             pd_pin = 1'h0;
  logic [1:0]       endec_sel = 2'h0;
  logic             irq;
  logic [3:0]       int_lines;
  logic             req_ready;
  logic             core_reset;
  logic             eep_start;
  irpc_pwr_out_type power;
  logic [15:0]      rd_val;
  logic [15:0]      ia;
  logic [7:0]       stat_exp = 8'h00;
  logic [7:0]       en_exp = 8'h00;
  logic [7:0]       ev;
  logic [1:0]       sel_exp = 2'h0;
  logic             pd_exp = 1'h0;
  logic             wake_exp = 1'h0;
  logic             lbm_exp = 1'h1;
  logic             fen_exp = 1'h0;
  logic             ce = 1'h1;
  logic             lbm_pin = 1'h1;
  logic [1:0]       seq [7] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h3, 2'h2, 2'h0};
  integer           seed = 32'h666992a3;
  int               err_count = 0;
  int               n_compared = 0;
  int               k;

  always #2 clock = ~clock;

  irpc_top irpc_top_inst (
    .i_clock                  (clock),
    .i_rst_n                  (rst_n),
    .i_clock_enable           (ce),
    .i_bus                    (bus),
    .o_rdata                  (rdata),
    .i_irq_event              (irq_event),
    .i_power_down_pin         (pd_pin),
    .i_external_endec_select  (endec_sel),
    .i_local_bus_mode_pin     (lbm_pin),
    .o_irq                    (irq),
    .o_interrupt_output_lines (int_lines),
    .o_request_ready_line     (req_ready),
    .o_core_reset             (core_reset),
    .o_eeprom_read_start      (eep_start),
    .o_power                  (power)
  );

  irpc_host_model irpc_host_model_inst (
    .i_clock (clock),
    .i_rdata (rdata),
    .o_bus   (bus)
  );

  task automatic close_out();
    $display("compared %0d values, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    irpc_host_model_inst.access(1'h1, a, d, rd_val);
  endtask

  task automatic rd(input logic [3:0] a);
    irpc_host_model_inst.access(1'h0, a, 16'h0000, rd_val);
  endtask

  task automatic pulse(input logic [7:0] e);
    @(posedge clock);
    irq_event <= e;
    @(posedge clock);
    irq_event <= 8'h00;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  function automatic irpc_pwr_out_type exp_pwr(logic pin, logic [1:0] sel);
    irpc_pwr_out_type p;
    p = '{tx: 1'h0, rx: 1'h0, link: 1'h0, modem_n: 1'h1};
    if (pin && sel != 2'h0)
      p = '{tx: 1'h1, rx: 1'h1, link: 1'h1, modem_n: 1'h0};
    else if (pd_exp || !(lbm_exp || fen_exp))
      p = '{tx: 1'h1, rx: 1'h1, link: 1'h1, modem_n: 1'h1};
    else if (wake_exp)
      p.tx = 1'h1;
    return p;
  endfunction

  // status word: bus mode flag at bit 8, one-hot power state below
  function automatic logic [15:0] pwr_word(logic pin, logic [1:0] sel);
    logic [3:0] s;
    s = (pin && sel != 2'h0) ? 4'h8 :
        (pd_exp || !(lbm_exp || fen_exp)) ? 4'h4 : wake_exp ? 4'h2 : 4'h1;
    return {7'h00, lbm_exp, 4'h0, s};
  endfunction

  task automatic check_power(input logic pin, input logic [1:0] sel);
    `CHK(power, exp_pwr(pin, sel))
    rd(`IRPC_OFF_PWR_STAT);
    `CHK(rd_val, pwr_word(pin, sel))
  endtask

  task automatic check_irq();
    logic e;
    e = |(stat_exp & en_exp) && (lbm_exp || fen_exp);
    `CHK(irq, e)
    `CHK(int_lines, (e ? 4'h1 << sel_exp : 4'h0))
    rd(`IRPC_OFF_CFG_STAT);
    `CHK(rd_val[`IRPC_BIT_STAT_INTR], e)
    rd(`IRPC_OFF_EVT_STAT);
    `CHK(rd_val, {8'h00, stat_exp})
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    k = 0;
    while (k < 10 && eep_start !== 1'h1)
    begin
      tick(1);
      k++;
    end
    `CHK(k < 10, 1'h1)
    tick(3);
    `CHK(req_ready, 1'h1)
    `CHK(core_reset, 1'h0)
    check_power(1'h0, 2'h0);
    rd(4'hF);
    `CHK(rd_val, 16'h0000)
    // fen left clear: local bus mode must still raise the interrupt
    for (int i = 0; i < 24; i++)
    begin
      en_exp = 8'($random(seed));
      wr(`IRPC_OFF_EVT_EN, {8'h00, en_exp});
      if (i % 4 == 0)
      begin
        sel_exp = 2'($random(seed));
        wr(`IRPC_OFF_CFG_REGS, {13'h0000, sel_exp, 1'h0});
      end
      ev = 8'($random(seed));
      pulse(ev);
      stat_exp |= ev;
      tick(2);
      check_irq();
      ev = 8'($random(seed));
      wr(`IRPC_OFF_EVT_STAT, {8'h00, ev});
      stat_exp &= ~ev;
      check_irq();
    end
    // a new event wins over a clear in the same cycle
    en_exp = 8'hFF;
    wr(`IRPC_OFF_EVT_EN, 16'h00FF);
    fork
      wr(`IRPC_OFF_EVT_STAT, 16'h00FF);
      pulse(8'h01);
    join
    stat_exp = 8'h01;
    tick(1);
    check_irq();
    // option soft reset
    wr(`IRPC_OFF_CFG_OPT, 16'h0080);
    `CHK(req_ready, 1'h0)
    `CHK(core_reset, 1'h1)
    `CHK(eep_start, 1'h1)
    tick(1);
    `CHK(eep_start, 1'h0)
    wr(`IRPC_OFF_CFG_REGS, 16'h0006);
    rd(`IRPC_OFF_CFG_REGS);
    `CHK(rd_val, 16'h0000)
    rd(`IRPC_OFF_EVT_EN);
    `CHK(rd_val, 16'h0000)
    rd(`IRPC_OFF_CFG_OPT);
    `CHK(rd_val, 16'h0080)
    `CHK(rdata, 16'h0080)
    tick(1);
    `CHK(rdata, 16'h0000)
    wr(`IRPC_OFF_CFG_OPT, 16'h0000);
    `CHK(req_ready, 1'h1)
    `CHK(core_reset, 1'h0)
    stat_exp = 8'h00;
    en_exp = 8'h00;
    sel_exp = 2'h0;
    check_irq();
    // core soft reset spares address, configuration and base words
    ia = 16'($random(seed));
    wr(`IRPC_OFF_IND_ADDR, ia);
    wr(`IRPC_OFF_BASE_ADDR, ~ia);
    wr(`IRPC_OFF_CFG_REGS, 16'h0004);
    wr(`IRPC_OFF_EVT_EN, 16'h00FF);
    wr(`IRPC_OFF_PWR_CTL, 16'h0001);
    wr(`IRPC_OFF_RX_CTL, 16'h8000);
    `CHK(core_reset, 1'h1)
    `CHK(eep_start, 1'h0)
    `CHK(req_ready, 1'h1)
    check_power(1'h0, 2'h0);
    rd(`IRPC_OFF_EVT_EN);
    `CHK(rd_val, 16'h0000)
    rd(`IRPC_OFF_IND_ADDR);
    `CHK(rd_val, ia)
    rd(`IRPC_OFF_BASE_ADDR);
    `CHK(rd_val, ~ia)
    rd(`IRPC_OFF_CFG_REGS);
    `CHK(rd_val, 16'h0004)
    wr(`IRPC_OFF_RX_CTL, 16'h0000);
    `CHK(core_reset, 1'h0)
    // power control sequence with random function enable
    foreach (seq[i])
    begin
      {pd_exp, wake_exp} = seq[i];
      fen_exp = 1'($random(seed));
      wr(`IRPC_OFF_CFG_OPT, {15'h0000, fen_exp});
      wr(`IRPC_OFF_PWR_CTL, {14'h0000, seq[i]});
      check_power(1'h0, 2'h0);
    end
    wr(`IRPC_OFF_CFG_STAT, 16'h0001);
    check_power(1'h0, 2'h0);
    wr(`IRPC_OFF_PWR_CTL, 16'h0001);
    wake_exp = 1'h1;
    @(posedge clock);
    pd_pin <= 1'h1;
    tick(6);
    check_power(1'h1, 2'h0);
    // clock enable low freezes the synchroniser and the power state
    @(posedge clock);
    ce <= 1'h0;
    endec_sel <= 2'h1 + 2'($unsigned($random(seed)) % 3);
    tick(6);
    `CHK(power, exp_pwr(1'h0, 2'h0))
    @(posedge clock);
    ce <= 1'h1;
    tick(6);
    check_power(1'h1, endec_sel);
    @(posedge clock);
    pd_pin <= 1'h0;
    tick(6);
    check_power(1'h0, endec_sel);
    // second reset outside local bus mode: function enable gates irq and power
    @(posedge clock);
    rst_n <= 1'h0;
    lbm_pin <= 1'h0;
    {lbm_exp, fen_exp, pd_exp, wake_exp, sel_exp, stat_exp, en_exp} = '0;
    tick(3);
    `CHK(core_reset, 1'h0)
    @(posedge clock);
    rst_n <= 1'h1;
    tick(3);
    `CHK(eep_start, 1'h1)
    check_power(1'h0, 2'h0);
    en_exp = 8'hFF;
    wr(`IRPC_OFF_EVT_EN, 16'h00FF);
    pulse(8'h10);
    stat_exp = 8'h10;
    tick(2);
    check_irq();
    fen_exp = 1'h1;
    wr(`IRPC_OFF_CFG_OPT, 16'h0001);
    check_irq();
    check_power(1'h0, 2'h0);
    close_out();
  end
endmodule // test_irq_reset_power_ctrl
`default_nettype wire
